/* File: sim/meter_model.sv */
module meter_model #(
  parameter int PERIOD = 1000
) (
  // Clock
  input wire logic aclk,
  // Wheel control and pick-up output
  input wire logic run,
  output logic pulse_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // Steady wheel: short pulse each period, flat while stopped
  always @(posedge aclk) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    pulse_out <= run && (cnt < 8);
  end
endmodule

/* File: sim/test_flow_totalizer_keypad_config.sv */
module test_flow_totalizer_keypad_config;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, btn_up = 0, btn_left = 0, btn_clear = 0;
  logic jumper_fitted = 1, cfg_defaulted = 0, hart_cmd = 0, run = 0;
  logic contact_in = 0;
  logic [3:0] wstrb = 4'hF;
  logic pickup_in, awready, wready, bvalid, arready, rvalid;
  logic banner_r, aborted_r, write_protect_r, nvm_wr_r;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] cursor_r;
  logic [27:0] edit_r;
  logic [15:0] loop_ua_r;
  flow_cfg_pkg::screen_t screen_r;
  // Rows: button code, screen after, cursor after (7 = not checked)
  logic [11:0] rows [17] = '{12'h310, 12'h110, 12'h211, 12'h212, 12'h213,
    12'h214, 12'h215, 12'h216, 12'h210, 12'h327, 12'h337, 12'h347,
    12'h307, 12'h757, 12'h107, 12'h310, 12'h407};
  int err_total = 0, comparisons = 0;
  flow_totalizer_keypad_config #(.DEBOUNCE_CYC(4), .FILTER_CYC(4),
    .TIMEOUT_CYC(32'h000186A0)) uut (.aclk, .aresetn, .awaddr,
    .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .btn_up, .btn_left,
    .btn_clear, .jumper_fitted, .contact_in, .pickup_in,
    .cfg_defaulted, .hart_cmd, .screen_r, .cursor_r, .edit_r, .banner_r,
    .aborted_r, .write_protect_r, .nvm_wr_r, .loop_ua_r);
  meter_model #(.PERIOD(1000)) pm (.aclk, .run, .pulse_out(pickup_in));
  // Free-running 100 MHz clock
  initial forever #5 aclk = ~aclk;
  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", s, e, g);
      err_total++;
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Write and read hold each channel until its own ready is seen
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && ++n < 50);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    int n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && ++n < 50);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Held long past debounce, then a full release before the next press
  task automatic press(input logic [2:0] c);
    {btn_clear, btn_left, btn_up} <= c;
    repeat (12) @(posedge aclk);
    {btn_clear, btn_left, btn_up} <= 3'h0;
    repeat (14) @(posedge aclk);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("loop", 32'h0FA0, 32'(loop_ua_r));
    cfg_defaulted <= 1'b1;
    @(posedge aclk);
    cfg_defaulted <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("banner", 32'h1, 32'(banner_r));
    foreach (rows[i]) begin
      press(rows[i][10:8]);
      chk("screen", 32'(rows[i][6:4]), 32'(screen_r));
      if (rows[i][2:0] != 3'h7) chk("cursor", 32'(rows[i][2:0]), 32'(cursor_r));
    end
    chk("banner", 32'h0, 32'(banner_r));
    axr(flow_cfg_pkg::A_FACTOR);
    chk("factor", 32'h1001000, rd);
    axr(8'h3C);
    chk("unmapped", 32'(flow_cfg_pkg::RESP_SLVERR), 32'(resp));
    press(3'h3);
    hart_cmd <= 1'b1;
    @(posedge aclk);
    hart_cmd <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("aborted", 32'h1, 32'(aborted_r));
    chk("abort screen", 32'h0, 32'(screen_r));
    press(3'h1);
    chk("aborted", 32'h0, 32'(aborted_r));
    axw(flow_cfg_pkg::A_CTRL, 32'h1);
    run <= 1'b1;
    press(3'h4);
    axr(flow_cfg_pkg::A_TOTAL);
    chk("total", 32'h0, rd);
    repeat (3000) @(posedge aclk);
    axr(flow_cfg_pkg::A_RATE);
    chk("rate", 32'h1, 32'(rd >= 99900099 && rd <= 99900100));
    chk("setpoint", 32'h1, 32'(loop_ua_r inside {[19980:19988]}));
    jumper_fitted <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("protect", 32'h1, 32'(write_protect_r));
    press(3'h3);
    chk("locked", 32'h0, 32'(screen_r));
    end_sim();
  end
  // Watchdog well beyond the expected run
  initial begin
    #200us;
    err_total++;
    end_sim();
  end
endmodule

/* File: verilog/flow_cfg_pkg.sv */
package flow_cfg_pkg;
  // Clock and timing figures
  localparam longint CLK_HZ = 64'h5F5E100;
  localparam longint DEBOUNCE_MS = 64'hA;
  localparam longint FILTER_US = 64'h7D0;
  localparam longint MIN_RATE_MILLIHZ = 64'h3C;
  localparam longint DEBOUNCE_CYC = DEBOUNCE_MS * CLK_HZ / 64'h3E8;
  localparam longint FILTER_CYC = FILTER_US * CLK_HZ / 64'hF4240;
  // Longest period still measured, rounded up to whole cycles
  localparam longint TIMEOUT_CYC =
    (CLK_HZ * 64'h3E8 + MIN_RATE_MILLIHZ - 64'h1) / MIN_RATE_MILLIHZ;
  // Microlitres per second = RATE_NUM / (period * factor_milli)
  localparam logic [63:0] RATE_NUM = 64'(CLK_HZ) * 64'h3B9ACA00;
  // One pulse adds a million; one millilitre drains the factor in thousandths
  localparam logic [63:0] PULSE_UL = 64'h00000000000F4240;
  // Keypad
  localparam int DIGITS = 7;
  localparam logic [3:0] FLOW_UNITS = 4'h9;
  localparam logic [1:0] VOL_UNITS = 2'h3;
  // Microlitres in one thousandth of a unit, so range values meet the rate
  localparam logic [31:0] ML_L = 32'h000003E8;
  localparam logic [31:0] ML_M3 = 32'h000F4240;
  localparam logic [31:0] ML_GAL = 32'h00000EC9;
  // Times in seconds
  localparam logic [15:0] SEC_M = 16'h003C;
  localparam logic [15:0] SEC_H = 16'h0E10;
  // Loop current in microamps
  localparam logic [15:0] LOOP_LO_UA = 16'h0FA0;
  localparam logic [15:0] LOOP_HI_UA = 16'h4E20;
  localparam logic [63:0] LOOP_SPAN_UA = 64'h3E80;
  // Factory defaults, packed decimal digits
  localparam logic [27:0] DEF_FACTOR = 28'h0001000;
  localparam logic [27:0] DEF_LOWER = 28'h0000000;
  localparam logic [27:0] DEF_UPPER = 28'h0100000;
  // Register byte addresses
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_FACTOR = 8'h08;
  localparam logic [7:0] A_UNITS = 8'h0C;
  localparam logic [7:0] A_LOWER = 8'h10;
  localparam logic [7:0] A_UPPER = 8'h14;
  localparam logic [7:0] A_TOTAL = 8'h18;
  localparam logic [7:0] A_RATE = 8'h1C;
  localparam logic [7:0] A_LOOP = 8'h20;
  localparam logic [7:0] A_EDIT = 8'h24;
  localparam logic [7:0] A_SERIAL = 8'h28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    SCR_NORMAL, SCR_FACTOR, SCR_UNITS, SCR_LOWER, SCR_UPPER, SCR_SERIAL
  } screen_t;
  typedef enum logic [1:0] {DIV_IDLE, DIV_RATE, DIV_SET} div_state_t;
endpackage

/* File: verilog/flow_totalizer_keypad_config.sv */
// Summary of operation
// - Defaults banner shows from defaults load until a full sequence ends.
// - Clear button leaves any programming screen, committing nothing.
// - Button pair enters factor entry: seven digits, four whole, three decimal.
// - Up button increments the blinking digit.
// - Left button moves cursor on; from seventh digit back to first.
// - Pair on factor screen stores factor and opens unit selection.
// - Up on unit screen steps the flow rate unit.
// - Left on unit screen steps the totalized volume unit.
// - Nine flow units: litres, cubic metres, gallons per s, min, h.
// - Three totalizer units: litres, cubic metres, gallons.
// - Pair after units opens the 4 mA range value screen.
// - Then a screen sets the 20 mA range value.
// - HART command during programming discards entries, aborts, lights indicator.
// - Abort indicator clears on a press of either pair button.
// - All three buttons show serial number; any press returns.
// - Clear on the normal screen zeroes totalizer; counting resumes.
// - Jumper absent: keypad ignored and HART write protection on.
// - Rate and volume come from pulses scaled by the factor.
// - Contact input debounced, counts correctly up to 130 Hz.
// - Contact input keeps measuring down to 0.06 Hz.
// - Pick-up input counts correctly up to 5000 Hz.
//
// Local design decisions: the address map and register access over AXI4-Lite.
module flow_totalizer_keypad_config #(
  parameter int DEBOUNCE_CYC = int'(flow_cfg_pkg::DEBOUNCE_CYC),
  parameter int FILTER_CYC = int'(flow_cfg_pkg::FILTER_CYC),
  parameter logic [31:0] TIMEOUT_CYC = 32'(flow_cfg_pkg::TIMEOUT_CYC),
  // Arbitrary serial number value
  parameter logic [31:0] SERIAL_NO = 32'h00000001
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Keypad and protection jumper
  input wire logic btn_up,
  input wire logic btn_left,
  input wire logic btn_clear,
  input wire logic jumper_fitted,
  // Meter inputs, memory and HART events
  input wire logic contact_in,
  input wire logic pickup_in,
  input wire logic cfg_defaulted,
  input wire logic hart_cmd,
  // Display and loop state
  output flow_cfg_pkg::screen_t screen_r,
  output logic [2:0] cursor_r,
  output logic [27:0] edit_r,
  output logic banner_r,
  output logic aborted_r,
  output logic write_protect_r,
  output logic nvm_wr_r,
  output logic [15:0] loop_ua_r
);
  if (DEBOUNCE_CYC < 2 || FILTER_CYC < 2 || TIMEOUT_CYC < 32'h4) begin : g_chk
    $error("Debounce, filter and timeout counts are too small");
  end

  function automatic logic [31:0] bcd2bin(input logic [27:0] b);
    logic [31:0] v;
    v = 32'h0;
    for (int i = flow_cfg_pkg::DIGITS - 1; i >= 0; i--) begin
      v = 32'(v * 32'hA) + 32'(b[i*4+:4]);
    end
    return v;
  endfunction

  function automatic logic [31:0] flow_ml(input logic [3:0] u);
    if (u >= 4'h6) return flow_cfg_pkg::ML_GAL;
    else if (u >= 4'h3) return flow_cfg_pkg::ML_M3;
    else return flow_cfg_pkg::ML_L;
  endfunction

  function automatic logic [15:0] flow_sec(input logic [3:0] u);
    case (u)
      4'h1, 4'h4, 4'h7: return flow_cfg_pkg::SEC_M;
      4'h2, 4'h5, 4'h8: return flow_cfg_pkg::SEC_H;
      default: return 16'h0001;
    endcase
  endfunction

  localparam int DW = $clog2(DEBOUNCE_CYC + 1);
  localparam int FW = $clog2(FILTER_CYC + 1);
  logic [2:0] raw, btn_st_r, chord_r, evt;
  logic [DW-1:0] btn_cnt_r [3];
  logic ev_up, ev_left, ev_clr, ev_pair, ev_all, ev_any, in_config_button_pair;
  logic [27:0] factor_r, factor_prev_r, lower_r, upper_r, pend_lower_r;
  logic [3:0] flow_unit_r, pend_fu_r;
  logic [1:0] tot_unit_r, pend_tu_r;
  logic input_sel_r;
  assign raw = {btn_clear, btn_left, btn_up};

  // Debounce each button with a stability counter
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 3; i++) begin
      if (!aresetn || raw[i] == btn_st_r[i]) begin
        btn_cnt_r[i] <= '0;
        if (!aresetn) btn_st_r[i] <= 1'b0;
      end else if (btn_cnt_r[i] == DW'(DEBOUNCE_CYC - 1)) begin
        btn_cnt_r[i] <= '0;
        btn_st_r[i] <= raw[i];
      end else begin
        btn_cnt_r[i] <= btn_cnt_r[i] + 1'b1;
      end
    end
  end

  // chord on release
  // Acting on release lets a chord finish before any single action fires
  always_ff @(posedge aclk) begin
    if (!aresetn || !jumper_fitted || btn_st_r == 3'h0) chord_r <= 3'h0;
    else chord_r <= chord_r | btn_st_r;
  end
  assign evt = (jumper_fitted && btn_st_r == 3'h0) ? chord_r : 3'h0;
  assign ev_up = evt == 3'h1;
  assign ev_left = evt == 3'h2;
  assign ev_clr = evt == 3'h4;
  assign ev_pair = evt == 3'h3;
  assign ev_all = evt == 3'h7;
  assign ev_any = evt != 3'h0;
  assign in_config_button_pair = screen_r inside {flow_cfg_pkg::SCR_FACTOR,
    flow_cfg_pkg::SCR_UNITS, flow_cfg_pkg::SCR_LOWER, flow_cfg_pkg::SCR_UPPER};

  // Menu sequence, edit buffer and stored configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      screen_r <= flow_cfg_pkg::SCR_NORMAL;
      cursor_r <= 3'h0;
      edit_r <= 28'h0;
      factor_r <= flow_cfg_pkg::DEF_FACTOR;
      factor_prev_r <= flow_cfg_pkg::DEF_FACTOR;
      lower_r <= flow_cfg_pkg::DEF_LOWER;
      upper_r <= flow_cfg_pkg::DEF_UPPER;
      pend_lower_r <= 28'h0;
      flow_unit_r <= 4'h0;
      tot_unit_r <= 2'h0;
      pend_fu_r <= 4'h0;
      pend_tu_r <= 2'h0;
    end else if (cfg_defaulted) begin
      factor_r <= flow_cfg_pkg::DEF_FACTOR;
      lower_r <= flow_cfg_pkg::DEF_LOWER;
      upper_r <= flow_cfg_pkg::DEF_UPPER;
      flow_unit_r <= 4'h0;
      tot_unit_r <= 2'h0;
      screen_r <= flow_cfg_pkg::SCR_NORMAL;
    end else if (hart_cmd && in_config_button_pair) begin
      factor_r <= factor_prev_r;
      screen_r <= flow_cfg_pkg::SCR_NORMAL;
    end else if (in_config_button_pair && ev_clr) begin
      screen_r <= flow_cfg_pkg::SCR_NORMAL;
    end else begin
      case (screen_r)
        flow_cfg_pkg::SCR_NORMAL: begin
          if (ev_all) begin
            screen_r <= flow_cfg_pkg::SCR_SERIAL;
          end else if (ev_pair) begin
            screen_r <= flow_cfg_pkg::SCR_FACTOR;
            edit_r <= factor_r;
            cursor_r <= 3'h0;
            factor_prev_r <= factor_r;
          end
        end
        flow_cfg_pkg::SCR_UNITS: begin
          if (ev_up) begin
            pend_fu_r <= (pend_fu_r == flow_cfg_pkg::FLOW_UNITS - 4'h1) ?
              4'h0 : pend_fu_r + 4'h1;
          end else if (ev_left) begin
            pend_tu_r <= (pend_tu_r == flow_cfg_pkg::VOL_UNITS - 2'h1) ?
              2'h0 : pend_tu_r + 2'h1;
          end else if (ev_pair) begin
            screen_r <= flow_cfg_pkg::SCR_LOWER;
            edit_r <= lower_r;
            cursor_r <= 3'h0;
          end
        end
        flow_cfg_pkg::SCR_SERIAL: begin
          if (ev_any) screen_r <= flow_cfg_pkg::SCR_NORMAL;
        end
        default: begin
          if (ev_up) begin
            edit_r[(3'h6 - cursor_r)*4+:4] <=
              (edit_r[(3'h6 - cursor_r)*4+:4] == 4'h9) ?
              4'h0 : edit_r[(3'h6 - cursor_r)*4+:4] + 4'h1;
          end else if (ev_left) begin
            cursor_r <= (cursor_r == 3'h6) ? 3'h0 : cursor_r + 3'h1;
          end else if (ev_pair && screen_r == flow_cfg_pkg::SCR_FACTOR) begin
            factor_r <= edit_r;
            pend_fu_r <= flow_unit_r;
            pend_tu_r <= tot_unit_r;
            screen_r <= flow_cfg_pkg::SCR_UNITS;
          end else if (ev_pair && screen_r == flow_cfg_pkg::SCR_LOWER) begin
            pend_lower_r <= edit_r;
            edit_r <= upper_r;
            cursor_r <= 3'h0;
            screen_r <= flow_cfg_pkg::SCR_UPPER;
          end else if (ev_pair) begin
            upper_r <= edit_r;
            lower_r <= pend_lower_r;
            flow_unit_r <= pend_fu_r;
            tot_unit_r <= pend_tu_r;
            screen_r <= flow_cfg_pkg::SCR_NORMAL;
          end
        end
      endcase
    end
  end

  // Memory write strobe, banner, abort indicator and protection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nvm_wr_r <= 1'b0;
      banner_r <= 1'b0;
      aborted_r <= 1'b0;
      write_protect_r <= 1'b0;
    end else begin
      nvm_wr_r <= !cfg_defaulted && !(hart_cmd && in_config_button_pair) && !ev_clr &&
        ev_pair && (screen_r == flow_cfg_pkg::SCR_FACTOR ||
        screen_r == flow_cfg_pkg::SCR_UPPER);
      if (cfg_defaulted) banner_r <= 1'b1;
      else if (ev_pair && screen_r == flow_cfg_pkg::SCR_UPPER &&
               !hart_cmd) banner_r <= 1'b0;
      if (hart_cmd && in_config_button_pair && !cfg_defaulted) aborted_r <= 1'b1;
      else if (evt[0] || evt[1]) aborted_r <= 1'b0;
      write_protect_r <= !jumper_fitted;
    end
  end

  // contact bounce filter, 2 ms settle below 130 Hz half period
  logic cont_st_r, meter_d_r, pulse;
  logic [FW-1:0] cont_cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || contact_in == cont_st_r) begin
      cont_cnt_r <= '0;
      if (!aresetn) cont_st_r <= 1'b0;
    end else if (cont_cnt_r == FW'(FILTER_CYC - 1)) begin
      cont_cnt_r <= '0;
      cont_st_r <= contact_in;
    end else begin
      cont_cnt_r <= cont_cnt_r + 1'b1;
    end
  end

  // pick-up taken directly, no filter to limit its rate
  always_ff @(posedge aclk) begin
    if (!aresetn) meter_d_r <= 1'b0;
    else meter_d_r <= input_sel_r ? pickup_in : cont_st_r;
  end
  assign pulse = (input_sel_r ? pickup_in : cont_st_r) && !meter_d_r;

  // period up to the 0.06 Hz limit before rate falls to zero
  logic [31:0] per_cnt_r, period_r, rate_r, total_ml_r;
  logic have_edge_r, need_rate_r, need_set_r, timeout;
  assign timeout = have_edge_r && per_cnt_r >= TIMEOUT_CYC;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_cnt_r <= 32'h0;
      period_r <= 32'h0;
      have_edge_r <= 1'b0;
    end else if (pulse) begin
      period_r <= per_cnt_r;
      per_cnt_r <= 32'h1;
      have_edge_r <= 1'b1;
    end else if (timeout) begin
      have_edge_r <= 1'b0;
      period_r <= 32'h0;
    end else if (have_edge_r) begin
      per_cnt_r <= per_cnt_r + 32'h1;
    end
  end

  // Shared serial divider: rate first, then loop setpoint
  flow_cfg_pkg::div_state_t div_st_r;
  logic [63:0] num_r, den_r, rem_r, quo_r, rx, lox, hix, rsh;
  logic [6:0] div_cnt_r;
  assign rx = 64'(rate_r) * 64'(flow_sec(flow_unit_r));
  assign lox = 64'(bcd2bin(lower_r)) * 64'(flow_ml(flow_unit_r));
  assign hix = 64'(bcd2bin(upper_r)) * 64'(flow_ml(flow_unit_r));
  assign rsh = {rem_r[62:0], num_r[63]};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_st_r <= flow_cfg_pkg::DIV_IDLE;
      need_rate_r <= 1'b0;
      need_set_r <= 1'b0;
      rate_r <= 32'h0;
      loop_ua_r <= flow_cfg_pkg::LOOP_LO_UA;
      {num_r, den_r, rem_r, quo_r} <= '0;
      div_cnt_r <= 7'h0;
    end else begin
      if (pulse && have_edge_r) need_rate_r <= 1'b1;
      case (div_st_r)
        flow_cfg_pkg::DIV_IDLE: begin
          if (timeout) begin
            rate_r <= 32'h0;
            need_set_r <= 1'b1;
          end else if (need_rate_r && !(pulse && have_edge_r)) begin
            need_rate_r <= 1'b0;
            num_r <= flow_cfg_pkg::RATE_NUM;
            den_r <= 64'(period_r) * 64'(bcd2bin(factor_r));
            {rem_r, quo_r} <= '0;
            div_cnt_r <= 7'h0;
            div_st_r <= flow_cfg_pkg::DIV_RATE;
          end else if (need_set_r) begin
            need_set_r <= 1'b0;
            if (rx <= lox || hix <= lox) begin
              loop_ua_r <= flow_cfg_pkg::LOOP_LO_UA;
            end else if (rx >= hix) begin
              loop_ua_r <= flow_cfg_pkg::LOOP_HI_UA;
            end else begin
              num_r <= 64'((rx - lox) * flow_cfg_pkg::LOOP_SPAN_UA);
              den_r <= hix - lox;
              {rem_r, quo_r} <= '0;
              div_cnt_r <= 7'h0;
              div_st_r <= flow_cfg_pkg::DIV_SET;
            end
          end
        end
        default: begin
          num_r <= {num_r[62:0], 1'b0};
          rem_r <= (rsh >= den_r) ? rsh - den_r : rsh;
          quo_r <= {quo_r[62:0], rsh >= den_r};
          div_cnt_r <= div_cnt_r + 7'h1;
          if (div_cnt_r == 7'h40) begin
            div_st_r <= flow_cfg_pkg::DIV_IDLE;
            if (div_st_r == flow_cfg_pkg::DIV_RATE) begin
              // Zero divisor means no factor: report no flow
              rate_r <= (den_r == 64'h0) ? 32'h0 : 32'(quo_r);
              need_set_r <= 1'b1;
            end else begin
              loop_ua_r <= flow_cfg_pkg::LOOP_LO_UA + 16'(quo_r);
            end
          end
        end
      endcase
    end
  end

  // totalizer in ml, one factor drained per cycle
  // Tiny factors at high rates outpace the drain; the backlog still counts
  logic [39:0] vol_acc_r;
  logic [39:0] fmilli;
  assign fmilli = 40'(bcd2bin(factor_r));
  always_ff @(posedge aclk) begin
    if (!aresetn || (screen_r == flow_cfg_pkg::SCR_NORMAL && ev_clr)) begin
      vol_acc_r <= 40'h0;
      total_ml_r <= 32'h0;
    end else if (fmilli != 40'h0) begin
      if (vol_acc_r >= fmilli) begin
        vol_acc_r <= vol_acc_r - fmilli +
          (pulse ? 40'(flow_cfg_pkg::PULSE_UL) : 40'h0);
        total_ml_r <= total_ml_r + 32'h1;
      end else if (pulse) begin
        vol_acc_r <= vol_acc_r + 40'(flow_cfg_pkg::PULSE_UL);
      end
    end
  end

  // AXI4-Lite write side; address and data taken in either order
  logic aw_got_r, w_got_r;
  logic [7:0] waddr_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {awready, wready, aw_got_r, w_got_r, bvalid, input_sel_r} <= '0;
      waddr_r <= 8'h0;
      bresp <= flow_cfg_pkg::RESP_OKAY;
    end else begin
      awready <= awvalid && !awready && !aw_got_r && !bvalid;
      wready <= wvalid && !wready && !w_got_r && !bvalid;
      if (awvalid && awready) begin
        aw_got_r <= 1'b1;
        waddr_r <= awaddr;
      end
      if (wvalid && wready) w_got_r <= 1'b1;
      if (aw_got_r && w_got_r && !bvalid) begin
        {aw_got_r, w_got_r, bvalid} <= 3'b001;
        if (waddr_r == flow_cfg_pkg::A_CTRL) begin
          if (wstrb[0]) input_sel_r <= wdata[0];
          bresp <= flow_cfg_pkg::RESP_OKAY;
        end else begin
          bresp <= flow_cfg_pkg::RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read side
  logic [31:0] rd_val;
  logic rd_err;
  always_comb begin
    rd_err = 1'b0;
    rd_val = 32'h0;
    if (araddr == flow_cfg_pkg::A_STATUS) rd_val = {20'h0, !jumper_fitted,
      aborted_r, banner_r, write_protect_r, 1'b0, cursor_r, 1'b0, screen_r};
    else if (araddr == flow_cfg_pkg::A_CTRL) rd_val = {31'h0, input_sel_r};
    else if (araddr == flow_cfg_pkg::A_FACTOR) rd_val = {4'h0, factor_r};
    else if (araddr == flow_cfg_pkg::A_UNITS)
      rd_val = {26'h0, tot_unit_r, flow_unit_r};
    else if (araddr == flow_cfg_pkg::A_LOWER) rd_val = {4'h0, lower_r};
    else if (araddr == flow_cfg_pkg::A_UPPER) rd_val = {4'h0, upper_r};
    else if (araddr == flow_cfg_pkg::A_TOTAL) rd_val = total_ml_r;
    else if (araddr == flow_cfg_pkg::A_RATE) rd_val = rate_r;
    else if (araddr == flow_cfg_pkg::A_LOOP) rd_val = {16'h0, loop_ua_r};
    else if (araddr == flow_cfg_pkg::A_EDIT) rd_val = {4'h0, edit_r};
    else if (araddr == flow_cfg_pkg::A_SERIAL) rd_val = SERIAL_NO;
    else rd_err = 1'b1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {arready, rvalid} <= 2'b00;
      rdata <= 32'h0;
      rresp <= flow_cfg_pkg::RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= rd_err ? flow_cfg_pkg::RESP_SLVERR : flow_cfg_pkg::RESP_OKAY;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence calm_s;
    !cfg_defaulted && !hart_cmd;
  endsequence
  sequence pair_factor_s;
    ev_pair && screen_r == flow_cfg_pkg::SCR_FACTOR ##0 calm_s;
  endsequence
  factor_store_a: assert property (pair_factor_s |=>
    nvm_wr_r && screen_r == flow_cfg_pkg::SCR_UNITS && factor_r == $past(edit_r))
    else $error("factor not stored on pair");
  hart_abort_a: assert property (hart_cmd && in_config_button_pair && !cfg_defaulted |=>
    aborted_r && screen_r == flow_cfg_pkg::SCR_NORMAL && !nvm_wr_r)
    else $error("HART abort not taken");
  keypad_lock_a: assert property (!jumper_fitted [*2] |->
    evt == 3'h0 ##1 write_protect_r)
    else $error("keypad active without jumper");
  total_clear_a: assert property (ev_clr &&
    screen_r == flow_cfg_pkg::SCR_NORMAL |=> total_ml_r == 32'h0)
    else $error("totalizer not cleared");
  cursor_wrap_a: assert property (ev_left && !cfg_defaulted &&
    !hart_cmd && cursor_r == 3'h6 &&
    screen_r inside {flow_cfg_pkg::SCR_FACTOR, flow_cfg_pkg::SCR_LOWER}
    |=> cursor_r == 3'h0) else $error("cursor did not wrap");
  clear_exit_a: assert property (ev_clr && in_config_button_pair && !cfg_defaulted &&
    !hart_cmd |=>
    screen_r == flow_cfg_pkg::SCR_NORMAL && !nvm_wr_r &&
    $stable(factor_r) && $stable(upper_r)) else $error("clear committed data");
  banner_set_a: assert property (cfg_defaulted |=> banner_r)
    else $error("banner missing after defaults");
  abort_clear_a: assert property (aborted_r && (evt[0] || evt[1]) &&
    !hart_cmd |=> !aborted_r) else $error("abort indicator stuck");
  serial_show_a: assert property (ev_all && !cfg_defaulted && !hart_cmd &&
    screen_r == flow_cfg_pkg::SCR_NORMAL |=> screen_r == flow_cfg_pkg::SCR_SERIAL)
    else $error("serial view not shown");
  loop_range_a: assert property (loop_ua_r >= flow_cfg_pkg::LOOP_LO_UA &&
    loop_ua_r <= flow_cfg_pkg::LOOP_HI_UA) else $error("setpoint out of range");
endmodule
